//--- design/tmc_defines.vh
/*
 * Constants of the timer main control block: register offsets, control
 * word fields, reset values and clock divider codes.
 * Assumes byte addresses on an 8-bit register port with 32-bit data.
 */
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH

`define TMC_AW              8
`define TMC_DW              32
`define TMC_CW              16

`define TMC_OFF_CTRL        8'h00
`define TMC_OFF_MASK        8'h0C
`define TMC_OFF_STAT        8'h10
`define TMC_OFF_EVGEN       8'h14
`define TMC_OFF_COUNT       8'h24
`define TMC_OFF_PRESC       8'h28
`define TMC_OFF_RELOAD      8'h2C
`define TMC_OFF_CMP         8'h34

`define TMC_CTRL_RST        32'h00000000
`define TMC_CTRL_WMASK      32'h00038FFF
`define TMC_ZERO16          16'h0000
`define TMC_ONE16           16'h0001
`define TMC_ZERO32          32'h00000000

`define TMC_B_RUN           0
`define TMC_B_UPSUP         1
`define TMC_B_UPSRC         2
`define TMC_B_SHOT          3
`define TMC_B_DIR           4
`define TMC_F_ALIGN_HI      6
`define TMC_F_ALIGN_LO      5
`define TMC_B_RBUF          7
`define TMC_F_DIV_HI        9
`define TMC_F_DIV_LO        8
`define TMC_B_PINBRK_N      10
`define TMC_B_CH1SRC        11
`define TMC_B_CLRSRC        15
`define TMC_B_LOCKBRK       16
`define TMC_B_VOLTBRK       17

`define TMC_ALIGN_EDGE      2'h0
`define TMC_ALIGN_DOWN      2'h1
`define TMC_ALIGN_UP        2'h2
`define TMC_ALIGN_BOTH      2'h3

`define TMC_DIV_1           2'h0
`define TMC_DIV_2           2'h1
`define TMC_DIV_4           2'h2
`define TMC_DIVCNT_W        2
`define TMC_DIVCNT_ZERO     2'h0
`define TMC_DIVCNT_ONE      2'h1
`define TMC_DIVCNT_THREE    2'h3

`define TMC_NFLAG           2
`define TMC_FLAG_UPD        0
`define TMC_FLAG_CMP        1
`define TMC_EVGEN_UPD       0

`endif

//--- design/tmc_sample_div.v
/*
 * Sampling clock divider: one-cycle tick at the kernel clock rate divided
 * by 1, 2 or 4 as the divide code says.
 * Assumes a synchronous active-high reset and a freezing clock enable.
 */
`include "tmc_defines.vh"

module tmc_sample_div (
   input  wire                     i_core_clk,
   input  wire                     i_rst,
   input  wire                     i_ce,
   input  wire [1:0]               i_div,
   output reg                      o_tick
);

   reg  [`TMC_DIVCNT_W-1:0] cnt_r;
   reg  [`TMC_DIVCNT_W-1:0] last;

   always @* begin
      case (i_div)
         `TMC_DIV_2: last = `TMC_DIVCNT_ONE;
         `TMC_DIV_4: last = `TMC_DIVCNT_THREE;
         // reserved code falls back to undivided
         default:    last = `TMC_DIVCNT_ZERO;
      endcase
   end

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         cnt_r  <= `TMC_DIVCNT_ZERO;
         o_tick <= 1'b0;
      end else if (i_ce) begin
         if (cnt_r >= last) begin
            cnt_r  <= `TMC_DIVCNT_ZERO;
            o_tick <= 1'b1;
         end else begin
            cnt_r  <= cnt_r + `TMC_DIVCNT_ONE;
            o_tick <= 1'b0;
         end
      end
   end

endmodule // tmc_sample_div

//--- design/tmc_top.v
/*
 * Timer main control: control word, counter with prescaler, update event
 * logic, shadowed reload/prescaler/compare values, break and source muxes,
 * sticky flags with mask and interrupt.
 * Assumes a register master with one-cycle strobes and synchronous inputs.
 */
// Local design decision: the strobed register port.
// Functional notes
// - sampling period is 1, 2, 4 kernel periods
// - buffered reload loads only at update event
// - alignment 00 counts one way per direction
// - center modes alternate; compare flag per code
// - direction read-only in center modes
// - single shot clears run at update event
// - update source limits update flag causes
// - update event copies preloads into shadows
// - suppression blocks update, still reinitialises counter
// - counter runs only with run bit; trigger sets it
// - voltage, lockup, pin break source enables
// - reference clear from trigger or comparator
// - channel 1 from pin or comparator
`include "tmc_defines.vh"

module tmc_top (
   input  wire                     i_core_clk,
   input  wire                     i_rst,
   input  wire                     i_ce,
   input  wire [`TMC_AW-1:0]       i_addr,
   input  wire [`TMC_DW-1:0]       i_wdata,
   input  wire                     i_wr,
   input  wire                     i_rd,
   output reg  [`TMC_DW-1:0]       o_rdata,
   input  wire                     i_slave_update,
   input  wire                     i_slave_reset,
   input  wire                     i_trigger_mode,
   input  wire                     i_trigger,
   input  wire                     i_ext_trig_clear,
   input  wire                     i_comp_clear,
   input  wire                     i_pin_chan1,
   input  wire                     i_comp_chan1,
   input  wire                     i_supply_low,
   input  wire                     i_core_lockup,
   input  wire                     i_pin_break,
   output reg                      o_ref_clear,
   output reg                      o_chan1_in,
   output reg                      o_break,
   output wire                     o_sampling_tick,
   output reg                      o_update_event,
   output reg                      o_count_down,
   output reg                      o_irq
);

   function hit;
      input [`TMC_AW-1:0] a;
      input [`TMC_AW-1:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   reg  [`TMC_DW-1:0]       ctrl_r;
   reg  [`TMC_CW-1:0]       cnt_r;
   reg  [`TMC_CW-1:0]       psc_cnt_r;
   reg  [`TMC_CW-1:0]       psc_pre_r;
   reg  [`TMC_CW-1:0]       psc_act_r;
   reg  [`TMC_CW-1:0]       arr_pre_r;
   reg  [`TMC_CW-1:0]       arr_act_r;
   reg  [`TMC_CW-1:0]       cmp_pre_r;
   reg  [`TMC_CW-1:0]       cmp_act_r;
   reg  [`TMC_NFLAG-1:0]    stat_r;
   reg  [`TMC_NFLAG-1:0]    mask_r;
   reg  [`TMC_NFLAG-1:0]    ev;
   reg  [`TMC_DW-1:0]       ctrl_nxt;
   reg  [`TMC_CW-1:0]       cnt_nxt;
   reg  [`TMC_DW-1:0]       rd_nxt;
   reg                      wrap;
   reg                      cmp_hit;

   wire [1:0]               align   = ctrl_r[`TMC_F_ALIGN_HI:`TMC_F_ALIGN_LO];
   wire                     center  = (align != `TMC_ALIGN_EDGE);
   wire                     down    = ctrl_r[`TMC_B_DIR];
   wire                     run     = ctrl_r[`TMC_B_RUN];
   wire                     upsup   = ctrl_r[`TMC_B_UPSUP];
   wire                     wr_ctrl = i_wr && hit(i_addr, `TMC_OFF_CTRL);
   wire                     wr_stat = i_wr && hit(i_addr, `TMC_OFF_STAT);
   wire                     wr_arr  = i_wr && hit(i_addr, `TMC_OFF_RELOAD);
   wire                     sw_update_request =
                               i_wr && hit(i_addr, `TMC_OFF_EVGEN) && i_wdata[`TMC_EVGEN_UPD];
   wire [`TMC_CW-1:0]       arr_eff = ctrl_r[`TMC_B_RBUF] ? arr_act_r : arr_pre_r;
   wire                     psc_tick = (psc_cnt_r == psc_act_r);
   wire                     step    = run && psc_tick;
   wire                     reinit  = sw_update_request || i_slave_reset || i_slave_update;
   wire                     update_event     = !upsup && ((step && wrap) || reinit);
   wire                     upd_flag = update_event && (!ctrl_r[`TMC_B_UPSRC] || (step && wrap));

   tmc_sample_div u_sample_div (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_ce       (i_ce),
      .i_div      (ctrl_r[`TMC_F_DIV_HI:`TMC_F_DIV_LO]),
      .o_tick     (o_sampling_tick)
   );

   // counting step and wrap detection
   always @* begin
      wrap    = 1'b0;
      cnt_nxt = cnt_r;
      if (!center) begin
         if (!down) begin
            wrap    = (cnt_r >= arr_eff);
            cnt_nxt = wrap ? `TMC_ZERO16 : cnt_r + `TMC_ONE16;
         end else begin
            wrap    = (cnt_r == `TMC_ZERO16);
            cnt_nxt = wrap ? arr_eff : cnt_r - `TMC_ONE16;
         end
      end else begin
         if (!down) begin
            wrap    = (cnt_r >= arr_eff);
            cnt_nxt = wrap ? arr_eff - `TMC_ONE16 : cnt_r + `TMC_ONE16;
         end else begin
            wrap    = (cnt_r == `TMC_ZERO16);
            cnt_nxt = wrap ? `TMC_ONE16 : cnt_r - `TMC_ONE16;
         end
      end
   end

   always @* begin
      case (align)
         `TMC_ALIGN_DOWN: cmp_hit = down;
         `TMC_ALIGN_UP:   cmp_hit = !down;
         `TMC_ALIGN_BOTH: cmp_hit = 1'b1;
         default:         cmp_hit = 1'b1;
      endcase
      cmp_hit = cmp_hit && step && (cnt_r == cmp_act_r);
   end

   always @* begin
      ev = {`TMC_NFLAG{1'b0}};
      ev[`TMC_FLAG_UPD] = upd_flag;
      ev[`TMC_FLAG_CMP] = cmp_hit;
   end

   // control word next value
   always @* begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl) begin
         ctrl_nxt = i_wdata & `TMC_CTRL_WMASK;
         if (center)
            ctrl_nxt[`TMC_B_DIR] = ctrl_r[`TMC_B_DIR];
      end
      if (center && step && wrap)
         ctrl_nxt[`TMC_B_DIR] = !down;
      if (update_event && ctrl_r[`TMC_B_SHOT])
         ctrl_nxt[`TMC_B_RUN] = 1'b0;
      if (i_trigger_mode && i_trigger)
         ctrl_nxt[`TMC_B_RUN] = 1'b1;
   end

   always @* begin
      case (i_addr)
         `TMC_OFF_CTRL:   rd_nxt = ctrl_r;
         `TMC_OFF_MASK:   rd_nxt = {{(`TMC_DW-`TMC_NFLAG){1'b0}}, mask_r};
         `TMC_OFF_STAT:   rd_nxt = {{(`TMC_DW-`TMC_NFLAG){1'b0}}, stat_r};
         `TMC_OFF_COUNT:  rd_nxt = {`TMC_ZERO16, cnt_r};
         `TMC_OFF_PRESC:  rd_nxt = {`TMC_ZERO16, psc_pre_r};
         `TMC_OFF_RELOAD: rd_nxt = {`TMC_ZERO16, arr_pre_r};
         `TMC_OFF_CMP:    rd_nxt = {`TMC_ZERO16, cmp_pre_r};
         // unmapped reads as zero
         default:         rd_nxt = `TMC_ZERO32;
      endcase
   end

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         ctrl_r    <= `TMC_CTRL_RST;
         cnt_r     <= `TMC_ZERO16;
         psc_cnt_r <= `TMC_ZERO16;
         psc_pre_r <= `TMC_ZERO16;
         psc_act_r <= `TMC_ZERO16;
         arr_pre_r <= `TMC_ZERO16;
         arr_act_r <= `TMC_ZERO16;
         cmp_pre_r <= `TMC_ZERO16;
         cmp_act_r <= `TMC_ZERO16;
         mask_r    <= {`TMC_NFLAG{1'b0}};
         o_rdata   <= `TMC_ZERO32;
      end else if (i_ce) begin
         ctrl_r <= ctrl_nxt;
         o_rdata <= i_rd ? rd_nxt : `TMC_ZERO32;
         if (i_wr && hit(i_addr, `TMC_OFF_MASK))
            mask_r <= i_wdata[`TMC_NFLAG-1:0];
         if (i_wr && hit(i_addr, `TMC_OFF_PRESC))
            psc_pre_r <= i_wdata[`TMC_CW-1:0];
         if (wr_arr)
            arr_pre_r <= i_wdata[`TMC_CW-1:0];
         if (i_wr && hit(i_addr, `TMC_OFF_CMP))
            cmp_pre_r <= i_wdata[`TMC_CW-1:0];
         if (update_event) begin
            psc_act_r <= psc_pre_r;
            arr_act_r <= arr_pre_r;
            cmp_act_r <= cmp_pre_r;
         end
         if (reinit) begin
            psc_cnt_r <= `TMC_ZERO16;
            cnt_r     <= (down && !center) ? arr_eff : `TMC_ZERO16;
         end else if (run) begin
            psc_cnt_r <= psc_tick ? `TMC_ZERO16 : psc_cnt_r + `TMC_ONE16;
            if (psc_tick)
               cnt_r <= cnt_nxt;
         end
         // software count write, overrides counting step, yields to hardware reinit
         if (i_wr && hit(i_addr, `TMC_OFF_COUNT) && !reinit)
            cnt_r <= i_wdata[`TMC_CW-1:0];
      end
   end

   // sticky flags, set wins over clear
   genvar g;
   generate
      for (g = 0; g < `TMC_NFLAG; g = g + 1) begin : g_flag
         always @(posedge i_core_clk) begin
            if (i_rst)
               stat_r[g] <= 1'b0;
            else if (i_ce) begin
               if (ev[g])
                  stat_r[g] <= 1'b1;
               else if (wr_stat && i_wdata[g])
                  stat_r[g] <= 1'b0;
            end
         end
      end
   endgenerate

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_ref_clear    <= 1'b0;
         o_chan1_in     <= 1'b0;
         o_break        <= 1'b0;
         o_update_event <= 1'b0;
         o_count_down   <= 1'b0;
         o_irq          <= 1'b0;
      end else if (i_ce) begin
         o_ref_clear <= ctrl_r[`TMC_B_CLRSRC] ? i_comp_clear : i_ext_trig_clear;
         o_chan1_in  <= ctrl_r[`TMC_B_CH1SRC] ? i_comp_chan1 : i_pin_chan1;
         o_break     <= (ctrl_r[`TMC_B_VOLTBRK] && i_supply_low) ||
                        (ctrl_r[`TMC_B_LOCKBRK] && i_core_lockup) ||
                        (!ctrl_r[`TMC_B_PINBRK_N] && i_pin_break);
         o_update_event <= update_event;
         o_count_down   <= down;
         // level irq from masked sticky bits
         o_irq <= |(stat_r & mask_r);
      end
   end

endmodule // tmc_top

//--- testbench/tmc_chk.sv
/* port-level assertions for tmc_top, bound below.
   assumes one kernel clock, sync reset, i_ce held high */
`include "tmc_defines.vh"
module tmc_chk (
   input wire                i_core_clk,
   input wire                i_rst,
   input wire                i_ce,
   input wire [`TMC_AW-1:0]  i_addr,
   input wire [`TMC_DW-1:0]  i_wdata,
   input wire                i_wr,
   input wire                i_rd,
   input wire [`TMC_DW-1:0]  o_rdata,
   input wire                i_ext_trig_clear,
   input wire                i_comp_clear,
   input wire                i_pin_chan1,
   input wire                i_comp_chan1,
   input wire                i_supply_low,
   input wire                i_core_lockup,
   input wire                i_pin_break,
   input wire                o_ref_clear,
   input wire                o_chan1_in,
   input wire                o_break,
   input wire                o_sampling_tick,
   input wire                o_update_event,
   input wire                o_count_down,
   input wire                o_irq
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   logic [17:0] ctl_r;
   logic [1:0]  msk_r;
   // software-only fields; run and center direction are not mirrored
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         ctl_r <= 18'h00000;
         msk_r <= 2'h0;
      end else if (i_ce && i_wr && i_addr == `TMC_OFF_CTRL) begin
         ctl_r <= i_wdata[17:0];
      end else if (i_ce && i_wr && i_addr == `TMC_OFF_MASK) begin
         msk_r <= i_wdata[1:0];
      end
   end
   AST_RDZERO: assert property (!$past(i_rd) |-> o_rdata == 32'h00000000)
      else $error("read data not zero outside read slot");
   AST_IRQMSK: assert property ($past(msk_r) == 2'h0 |-> !o_irq)
      else $error("interrupt with all sources masked");
   AST_REFCLR: assert property (!$past(i_rst) |-> o_ref_clear ==
      ($past(ctl_r[15]) ? $past(i_comp_clear) : $past(i_ext_trig_clear)))
      else $error("reference clear from wrong source");
   AST_CHAN1: assert property (!$past(i_rst) |-> o_chan1_in ==
      ($past(ctl_r[11]) ? $past(i_comp_chan1) : $past(i_pin_chan1)))
      else $error("channel one from wrong source");
   AST_BREAK: assert property (!$past(i_rst) |-> o_break == $past(
      (ctl_r[17] & i_supply_low) | (ctl_r[16] & i_core_lockup) | (!ctl_r[10] & i_pin_break)))
      else $error("break output wrong");
   AST_DIV2: assert property (o_sampling_tick && $past(ctl_r[9:8]) == 2'h1 &&
      $past(ctl_r[9:8], 3) == 2'h1 |-> !$past(o_sampling_tick) && $past(o_sampling_tick, 2))
      else $error("sampling tick spacing not two");
   AST_DIV4: assert property (o_sampling_tick && $past(ctl_r[9:8]) == 2'h2 &&
      $past(ctl_r[9:8], 5) == 2'h2 |-> !$past(o_sampling_tick) && !$past(o_sampling_tick, 2)
      && !$past(o_sampling_tick, 3) && $past(o_sampling_tick, 4))
      else $error("sampling tick spacing not four");
   AST_DIR: assert property (i_ce && i_wr && i_addr == `TMC_OFF_CTRL &&
      i_wdata[6:5] == 2'h0 && ctl_r[6:5] == 2'h0 |-> ##2 o_count_down == $past(i_wdata[4], 2))
      else $error("edge mode direction not taken from write");
   AST_SUPP: assert property ($past(ctl_r[1]) && $past(ctl_r[1], 2) &&
      $past(ctl_r[1], 3) |-> !o_update_event)
      else $error("update event while suppressed");
   COV_IRQ: cover property (o_irq);
   COV_UPD: cover property (o_update_event);
   COV_BRK: cover property (o_break);
endmodule // tmc_chk

bind tmc_top tmc_chk u_tmc_chk (.i_core_clk, .i_rst, .i_ce, .i_addr, .i_wdata, .i_wr,
   .i_rd, .o_rdata, .i_ext_trig_clear, .i_comp_clear, .i_pin_chan1, .i_comp_chan1,
   .i_supply_low, .i_core_lockup, .i_pin_break, .o_ref_clear, .o_chan1_in, .o_break,
   .o_sampling_tick, .o_update_event, .o_count_down, .o_irq);

//--- testbench/tmc_tb.sv
/* self-checking bench for tmc_top: register tasks, event timing.
   assumes the checker binds itself to tmc_top */
`include "tmc_defines.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_core_clk = 0, i_rst = 1, i_ce = 1, i_wr = 0, i_rd = 0, i_trigger = 0, d;
   logic i_slave_update = 0, i_slave_reset = 0, i_trigger_mode = 0, i_pin_break = 1;
   logic i_ext_trig_clear = 0, i_comp_clear = 1, i_pin_chan1 = 1, i_comp_chan1 = 0;
   logic i_supply_low = 0, i_core_lockup = 0;
   logic [7:0]  i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h00000000;
   wire [31:0]  o_rdata;
   wire o_ref_clear, o_chan1_in, o_break, o_sampling_tick, o_update_event, o_count_down, o_irq;
   int err_count = 0, checks = 0, cyc = 0, ev_at = 0, gap = 0;
   always #4 i_core_clk = ~i_core_clk;
   tmc_top u_tmc_top (.i_core_clk, .i_rst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_slave_update, .i_slave_reset, .i_trigger_mode, .i_trigger, .i_ext_trig_clear,
      .i_comp_clear, .i_pin_chan1, .i_comp_chan1, .i_supply_low, .i_core_lockup,
      .i_pin_break, .o_ref_clear, .o_chan1_in, .o_break, .o_sampling_tick, .o_update_event,
      .o_count_down, .o_irq);
   // cycles between update pulses
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (o_update_event === 1'b1) begin
         gap <= cyc - ev_at;
         ev_at <= cyc;
      end
   end
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_core_clk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask
   task rc(input string n, input logic [7:0] a, input logic [31:0] e);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      // look while the read data stand, clear of the launching edge
      #1;
      chk(n, o_rdata, e);
   endtask
   // bounded wait; gap check skipped when e is zero
   task wev(input int e);
      int k;
      k = 0;
      @(posedge i_core_clk);
      while (o_update_event !== 1'b1 && k < 300) begin
         @(posedge i_core_clk);
         k++;
      end
      #1;
      chk("event seen", k < 300, 1);
      if (e > 0)
         chk("gap", gap, e);
   endtask
   task finish_test;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge i_core_clk);
      err_count++;
      finish_test;
   end
   initial begin
      repeat (4) @(posedge i_core_clk);
      i_rst <= 1'b0;
      rc("ctrl reset", `TMC_OFF_CTRL, 0);
      rc("unmapped", 8'h40, 0);
      wr(`TMC_OFF_CTRL, 32'hFFFC7000);
      rc("reserved", `TMC_OFF_CTRL, 0);
      wr(`TMC_OFF_CTRL, 32'h00038F1E);
      rc("ctrl", `TMC_OFF_CTRL, 32'h00038F1E);
      chk("pin break off", o_break, 0);
      wr(`TMC_OFF_CTRL, 32'h100);
      repeat (12) @(posedge i_core_clk);
      wr(`TMC_OFF_CTRL, 32'h200);
      repeat (12) @(posedge i_core_clk);
      wr(`TMC_OFF_CTRL, 0);
      rc("ctrl", `TMC_OFF_CTRL, 0);
      chk("pin break on", o_break, 1);
      chk("tick undivided", o_sampling_tick, 1);
      wr(`TMC_OFF_RELOAD, 5);
      wr(`TMC_OFF_CTRL, 1);
      wev(0);
      wev(6);
      wr(`TMC_OFF_RELOAD, 9);
      wev(10);
      wr(`TMC_OFF_CTRL, 32'h81);
      wev(0);
      wr(`TMC_OFF_RELOAD, 5);
      wev(10);
      wev(6);
      wr(`TMC_OFF_CTRL, 32'h11);
      wev(0);
      wev(6);
      wr(`TMC_OFF_CTRL, 0);
      wr(`TMC_OFF_MASK, 1);
      rc("status", `TMC_OFF_STAT, 3);
      chk("irq on", o_irq, 1);
      wr(`TMC_OFF_STAT, 1);
      rc("w1c", `TMC_OFF_STAT, 2);
      chk("irq off", o_irq, 0);
      wr(`TMC_OFF_CTRL, 32'h09);
      wev(0);
      rc("single shot", `TMC_OFF_CTRL, 32'h08);
      wr(`TMC_OFF_STAT, 3);
      wr(`TMC_OFF_CTRL, 32'h04);
      wr(`TMC_OFF_EVGEN, 1);
      rc("wrap only", `TMC_OFF_STAT, 0);
      wr(`TMC_OFF_CTRL, 0);
      wr(`TMC_OFF_EVGEN, 1);
      rc("sw update", `TMC_OFF_STAT, 1);
      wr(`TMC_OFF_STAT, 1);
      wr(`TMC_OFF_CTRL, 32'h02);
      wr(`TMC_OFF_COUNT, 4);
      wr(`TMC_OFF_EVGEN, 1);
      rc("suppressed", `TMC_OFF_STAT, 0);
      rc("reinit", `TMC_OFF_COUNT, 0);
      wr(`TMC_OFF_CTRL, 0);
      @(posedge i_core_clk);
      i_slave_update <= 1'b1;
      @(posedge i_core_clk);
      i_slave_update <= 1'b0;
      rc("slave update", `TMC_OFF_STAT, 1);
      i_trigger_mode <= 1'b1;
      {i_ext_trig_clear, i_comp_clear, i_core_lockup, i_supply_low} <= 4'hB;
      {i_pin_chan1, i_comp_chan1} <= 2'h1;
      @(posedge i_core_clk);
      i_trigger <= 1'b1;
      @(posedge i_core_clk);
      i_trigger <= 1'b0;
      rc("trigger run", `TMC_OFF_CTRL, 1);
      chk("ref clear", o_ref_clear, 1);
      chk("chan1 in", o_chan1_in, 0);
      wr(`TMC_OFF_CTRL, 0);
      wr(`TMC_OFF_CTRL, 32'h21);
      wev(0);
      wev(5);
      d = o_count_down;
      wr(`TMC_OFF_CTRL, 32'h31);
      wev(5);
      chk("dir flips", o_count_down, !d);
      finish_test;
   end
endmodule // tb
